//--- rtl/mmd_pkg.sv
// Package for the memory mode, overlay decode and select block
package mmd_pkg;

    // ****************************************************************
    // Register map (byte address, word index is a quarter)
    // ****************************************************************
    localparam logic [7:0] REG_CONFIG    = 8'h00;
    localparam logic [7:0] REG_OVERLAY   = 8'h04;
    localparam logic [7:0] REG_WAIT      = 8'h08;
    localparam logic [7:0] REG_SELECT    = 8'h0c;
    localparam logic [7:0] REG_SYSCTL    = 8'h10;
    localparam logic [7:0] REG_STATUS    = 8'h14;

    // ****************************************************************
    // Field layouts and reset values
    // ****************************************************************
    localparam int SYSCTL_BYTE_OFF_BIT = 3;
    localparam logic [3:0] SEL_EN_RESET = 4'hb; // prog, data, io set; byte clear
    localparam int SEL_PROG = 0;
    localparam int SEL_DATA = 1;
    localparam int SEL_BYTE = 2;
    localparam int SEL_IO   = 3;
    localparam int BOOT_WORDS = 32;
    localparam logic [1:0] OVL_INTERNAL = 2'h0;
    localparam logic [1:0] OVL_EXT1     = 2'h1;
    localparam logic [1:0] OVL_EXT2     = 2'h2;
    localparam logic [13:0] OVL_WIN_BASE = 14'h2000;
    localparam int DM_CTRL_REGS   = 32;
    localparam int DM_USER_LARGE  = 16352;
    localparam int DM_USER_SMALL  = 8160;
    localparam int IO_ADDR_BITS   = 11;
    localparam int IO_REGION_BITS = 2;

    typedef enum logic [4:0] {
        MMD_RESET    = 5'h01,
        MMD_BYTEBOOT = 5'h02,
        MMD_HOSTBOOT = 5'h04,
        MMD_RUN      = 5'h08,
        MMD_RESERVED = 5'h10
    } mmd_state_e;

    typedef struct packed {
        logic host_mode;
        logic autoboot_off;
        logic host_dma_src;
    } mmd_straps_s;

    // Bit order matches the select enable register: io is bit 3, prog is bit 0
    typedef struct packed {
        logic        io;
        logic        byte_sp;
        logic        data;
        logic        prog;
    } mmd_sel_s;

endpackage : mmd_pkg

//--- rtl/mmd_top.sv
// Memory mode straps, overlay address decode, wait-state and composite select logic
// Behaviour
// - Memory map chosen only during reset from the shared flag pin strap.
// - All three straps are sampled only while reset is held low.
// - Memory-map strap 0 gives full memory mode, 1 gives host mode.
// - Autoboot strap 0 enables booting after reset, 1 disables it.
// - Boot-source strap 0 selects byte DMA, 1 selects host DMA.
// - Straps 000 or 100 hold execution until 32 byte-DMA words load.
// - Straps 010 start at external location 0, full mode, no wait.
// - Straps 101 hold execution until program word 0 written by host.
// - Program overlay 1/2 drives A13 0/1 and low 13 address bits.
// - Data overlay nonzero selects external overlay with A13 per overlay.
// - Host mode limits overlay addressing to A0, no external execution.
// - Internal data takes one cycle; external inserts data wait count.
// - Top 32 data words are control registers; user space shrinks. The code gives them no decode; in the window they follow the data overlay.
// - I/O space is 2048 words on the lower 11 address bits.
// - I/O waits come from one of four 3-bit region registers.
// - Combined select asserts when any enabled space select asserts.
// - Combined select has the same timing and gating as space selects.
// - Select enables reset to 1 except the byte-space enable.
// - Byte-space select suppressed when system control bit 3 is 1.
module mmd_top #(
    parameter int DM_WORDS = 16384
) (
    input  wire logic        MCLK,
    input  wire logic        ARST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        MODE_A,
    input  wire logic        MODE_B,
    input  wire logic        SHARED_FLAG_PIN_I,
    input  wire logic        RESET_PIN_N,
    input  wire logic        BYTE_DMA_WORD_DONE,
    input  wire logic        HOST_PM0_WRITTEN,
    input  wire logic        CORE_PROG_REQ,
    input  wire logic        CORE_DATA_REQ,
    input  wire logic        CORE_BYTE_REQ,
    input  wire logic        CORE_IO_REQ,
    input  wire logic [13:0] CORE_ADDR,
    input  wire logic        BUS_GRANTED,
    output logic             EXEC_HOLD_N,
    output logic             START_EXTERNAL,
    output logic             BYTE_BOOT_REQ,
    output logic             HOST_MODE,
    output logic [13:0]      EXT_ADDR,
    output logic             PROGRAM_SPACE_SELECT_N,
    output logic             DATA_SPACE_SELECT_N,
    output logic             BYTE_SPACE_SELECT_N,
    output logic             IO_SPACE_SELECT_N,
    output logic             COMBINED_SELECT_N,
    output logic [2:0]       WAIT_STATES,
    output logic             INTERNAL_ACCESS
);

    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= {RESET_PIN_N, SHARED_FLAG_PIN_I, MODE_B, MODE_A};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        mmd_pkg::mmd_state_e  st;
        mmd_pkg::mmd_straps_s straps;
        logic [5:0]           boot_cnt;
        logic [1:0]           pm_ovl;
        logic [1:0]           dm_ovl;
        logic [2:0]           data_wait_count;
        logic [11:0]          io_wait;
        logic [3:0]           sel_en;
        logic                 byte_off;
        logic [31:0]          rdata;
    } mmd_regs_s;

    mmd_regs_s r_q;
    mmd_regs_s r_d;
    logic      in_reset;
    logic      dm_internal;
    logic [2:0] io_wait_sel;
    logic [1:0] io_region;
    logic       in_window;

    assign in_reset  = !pin_s2_q[3];
    assign io_region = CORE_ADDR[mmd_pkg::IO_ADDR_BITS-1 -: mmd_pkg::IO_REGION_BITS];
    // Top words of data memory get no decode of their own; in the window they follow the overlay
    // Only the upper window is overlaid; lower addresses always stay on chip
    assign in_window   = (CORE_ADDR >= mmd_pkg::OVL_WIN_BASE);
    assign dm_internal = (r_q.dm_ovl == mmd_pkg::OVL_INTERNAL) || !in_window;

    always_comb begin
        io_wait_sel = 3'h0;
        for (int i = 0; i < 4; i++) begin
            if (io_region == 2'(i)) begin
                io_wait_sel = r_q.io_wait[i*3 +: 3];
            end
        end
    end

    always_comb begin
        r_d = r_q;
        if (in_reset) begin
            // Straps are only honoured while the reset pin is low
            r_d.straps = '{host_mode:    pin_s2_q[2],
                           autoboot_off: pin_s2_q[1],
                           host_dma_src: pin_s2_q[0]};
            r_d.st       = mmd_pkg::MMD_RESET;
            r_d.boot_cnt = 6'h0;
        end else begin
            unique case (r_q.st)
                mmd_pkg::MMD_RESET: begin
                    unique case ({r_q.straps.host_mode, r_q.straps.autoboot_off,
                                  r_q.straps.host_dma_src})
                        3'h0, 3'h4: r_d.st = mmd_pkg::MMD_BYTEBOOT;
                        3'h2:       r_d.st = mmd_pkg::MMD_RUN;
                        3'h5:       r_d.st = mmd_pkg::MMD_HOSTBOOT;
                        default:    r_d.st = mmd_pkg::MMD_RESERVED;
                    endcase
                end
                mmd_pkg::MMD_BYTEBOOT: begin
                    if (BYTE_DMA_WORD_DONE) begin
                        r_d.boot_cnt = r_q.boot_cnt + 6'h1;
                        if (r_q.boot_cnt == 6'(mmd_pkg::BOOT_WORDS - 1)) begin
                            r_d.st = mmd_pkg::MMD_RUN;
                        end
                    end
                end
                mmd_pkg::MMD_HOSTBOOT: begin
                    if (HOST_PM0_WRITTEN) begin
                        r_d.st = mmd_pkg::MMD_RUN;
                    end
                end
                mmd_pkg::MMD_RUN: begin
                end
                mmd_pkg::MMD_RESERVED: begin
                end
            endcase
        end
        // Register writes
        if (WR) begin
            unique case (ADDR)
                mmd_pkg::REG_OVERLAY: begin
                    r_d.pm_ovl = WDATA[1:0];
                    r_d.dm_ovl = WDATA[5:4];
                end
                mmd_pkg::REG_WAIT: begin
                    r_d.data_wait_count   = WDATA[2:0];
                    r_d.io_wait = WDATA[15:4];
                end
                mmd_pkg::REG_SELECT: r_d.sel_en = WDATA[3:0];
                mmd_pkg::REG_SYSCTL: r_d.byte_off = WDATA[mmd_pkg::SYSCTL_BYTE_OFF_BIT];
                default: begin
                end
            endcase
        end
        r_d.rdata = 32'h0;
        if (RD) begin
            unique case (ADDR)
                mmd_pkg::REG_CONFIG:
                    r_d.rdata = {29'h0, r_q.straps};
                mmd_pkg::REG_OVERLAY:
                    r_d.rdata = {26'h0, r_q.dm_ovl, 2'h0, r_q.pm_ovl};
                mmd_pkg::REG_WAIT:
                    r_d.rdata = {16'h0, r_q.io_wait, 1'b0, r_q.data_wait_count};
                mmd_pkg::REG_SELECT:
                    r_d.rdata = {28'h0, r_q.sel_en};
                mmd_pkg::REG_SYSCTL:
                    r_d.rdata = {28'h0, r_q.byte_off, 3'h0};
                mmd_pkg::REG_STATUS:
                    r_d.rdata = {21'h0, r_q.boot_cnt, r_q.st};
                default: r_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            r_q          <= '0;
            r_q.st       <= mmd_pkg::MMD_RESET;
            r_q.sel_en   <= mmd_pkg::SEL_EN_RESET;
            r_q.data_wait_count    <= 3'h7;
            r_q.io_wait  <= 12'hfff;
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    mmd_pkg::mmd_sel_s sel;
    logic              ext_ovl;
    logic [13:0]       ovl_addr;

    always_comb begin
        // Selects only assert once the bus is ours, same gate for all
        sel.prog    = CORE_PROG_REQ && BUS_GRANTED && !r_q.straps.host_mode;
        sel.data    = CORE_DATA_REQ && BUS_GRANTED;
        sel.byte_sp = CORE_BYTE_REQ && BUS_GRANTED && !r_q.byte_off;
        sel.io      = CORE_IO_REQ && BUS_GRANTED;
        ext_ovl     = 1'b0;
        ovl_addr    = CORE_ADDR - mmd_pkg::OVL_WIN_BASE;
        EXT_ADDR    = 14'h0;
        if (sel.io) begin
            EXT_ADDR = {3'h0, CORE_ADDR[mmd_pkg::IO_ADDR_BITS-1:0]};
        end else if (sel.prog && in_window && r_q.pm_ovl != mmd_pkg::OVL_INTERNAL) begin
            EXT_ADDR = {r_q.pm_ovl == mmd_pkg::OVL_EXT2, ovl_addr[12:0]};
        end else if (sel.data && !dm_internal) begin
            ext_ovl  = 1'b1;
            EXT_ADDR = {r_q.dm_ovl == mmd_pkg::OVL_EXT2, ovl_addr[12:0]};
        end
        if (r_q.straps.host_mode) begin
            EXT_ADDR = {13'h0, EXT_ADDR[0]};
        end
    end

    assign PROGRAM_SPACE_SELECT_N = !sel.prog;
    assign DATA_SPACE_SELECT_N    = !sel.data;
    assign BYTE_SPACE_SELECT_N    = !sel.byte_sp;
    assign IO_SPACE_SELECT_N      = !sel.io;
    assign COMBINED_SELECT_N      = !(|(sel & r_q.sel_en));
    assign WAIT_STATES = sel.io ? io_wait_sel : (ext_ovl ? r_q.data_wait_count : 3'h0);
    assign INTERNAL_ACCESS = CORE_DATA_REQ && dm_internal;
    assign EXEC_HOLD_N    = (r_q.st == mmd_pkg::MMD_RUN);
    assign START_EXTERNAL = (r_q.st == mmd_pkg::MMD_RUN) && r_q.straps.autoboot_off
                            && !r_q.straps.host_mode;
    assign BYTE_BOOT_REQ  = (r_q.st == mmd_pkg::MMD_BYTEBOOT);
    assign HOST_MODE      = r_q.straps.host_mode;
    assign RDATA          = r_q.rdata;

endmodule : mmd_top

//--- tb/mmd_strap_drv.sv
// Reset-time strap driver model for the three configuration pins
module mmd_strap_drv (
    input  wire logic       MCLK,
    input  wire logic       RESET_PIN_N,
    input  wire logic [2:0] straps,
    output logic            MODE_A,
    output logic            MODE_B,
    output logic            SHARED_FLAG_PIN_I
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] pins;
    // Released pins toggle every cycle so a late sample shows as a wrong mode
    always @(posedge MCLK or negedge RESET_PIN_N) begin
        pins <= RESET_PIN_N ? ~pins : straps;
    end
    assign {SHARED_FLAG_PIN_I, MODE_B, MODE_A} = pins;
endmodule : mmd_strap_drv

//--- tb/mmd_top_chk.sv
// Port-level assertions for the memory decode block
module mmd_chk (
    input wire logic        MCLK,
    input wire logic        ARST_N,
    input wire logic        RESET_PIN_N,
    input wire logic        CORE_PROG_REQ,
    input wire logic        CORE_IO_REQ,
    input wire logic        BUS_GRANTED,
    input wire logic        EXEC_HOLD_N,
    input wire logic        START_EXTERNAL,
    input wire logic        BYTE_BOOT_REQ,
    input wire logic        HOST_MODE,
    input wire logic [13:0] EXT_ADDR,
    input wire logic        PROGRAM_SPACE_SELECT_N,
    input wire logic        DATA_SPACE_SELECT_N,
    input wire logic        BYTE_SPACE_SELECT_N,
    input wire logic        IO_SPACE_SELECT_N,
    input wire logic        COMBINED_SELECT_N
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    wire logic none_n = &{PROGRAM_SPACE_SELECT_N, DATA_SPACE_SELECT_N,
                          BYTE_SPACE_SELECT_N, IO_SPACE_SELECT_N};
    property p_cms; !COMBINED_SELECT_N |-> !none_n; endproperty
    a_cms: assert property (p_cms) else $error("combined select without source");
    property p_cms_gnt; !COMBINED_SELECT_N |-> BUS_GRANTED; endproperty
    a_cms_gnt: assert property (p_cms_gnt) else $error("combined select ungated");
    property p_prog; !PROGRAM_SPACE_SELECT_N |-> CORE_PROG_REQ && BUS_GRANTED; endproperty
    a_prog: assert property (p_prog) else $error("program select without request");
    property p_io; !IO_SPACE_SELECT_N |-> CORE_IO_REQ && BUS_GRANTED; endproperty
    a_io: assert property (p_io) else $error("io select without request");
    // Six quiet cycles clear the synchroniser and the strap latch pipeline
    property p_strap; RESET_PIN_N [*6] |-> $stable(HOST_MODE); endproperty
    a_strap: assert property (p_strap) else $error("mode changed after reset");
    property p_start; START_EXTERNAL |-> EXEC_HOLD_N && !HOST_MODE; endproperty
    a_start: assert property (p_start) else $error("external start in wrong mode");
    property p_boot; BYTE_BOOT_REQ |-> !EXEC_HOLD_N; endproperty
    a_boot: assert property (p_boot) else $error("running during byte boot");
    property p_haddr; HOST_MODE |-> EXT_ADDR[13:1] == 13'h0000; endproperty
    a_haddr: assert property (p_haddr) else $error("host mode wide address");
    c_boot: cover property (BYTE_BOOT_REQ ##1 !BYTE_BOOT_REQ);
    c_start: cover property (START_EXTERNAL);
    c_cms: cover property (!COMBINED_SELECT_N && HOST_MODE);
endmodule : mmd_chk

bind mmd_top mmd_chk chk_u (.*);

//--- tb/mmd_top_tb.sv
// Self-checking bench for the memory decode block
module mmd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        MCLK = 1'b0, ARST_N = 1'b0, WR = 1'b0, RD = 1'b0, RESET_PIN_N = 1'b0;
    logic        BYTE_DMA_WORD_DONE = 1'b0, HOST_PM0_WRITTEN = 1'b0, BUS_GRANTED = 1'b0;
    logic        CORE_PROG_REQ = 1'b0, CORE_DATA_REQ = 1'b0;
    logic        CORE_BYTE_REQ = 1'b0, CORE_IO_REQ = 1'b0;
    logic [7:0]  ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic [13:0] CORE_ADDR = 14'h0, EXT_ADDR;
    logic [2:0]  straps = 3'h0, WAIT_STATES;
    logic        MODE_A, MODE_B, SHARED_FLAG_PIN_I, EXEC_HOLD_N, START_EXTERNAL;
    logic        BYTE_BOOT_REQ, HOST_MODE, INTERNAL_ACCESS, COMBINED_SELECT_N;
    logic        PROGRAM_SPACE_SELECT_N, DATA_SPACE_SELECT_N;
    logic        BYTE_SPACE_SELECT_N, IO_SPACE_SELECT_N;
    int          errors = 0, n_compared = 0;

    mmd_top dut_u (.*);
    mmd_strap_drv drv_u (.*);

    initial begin
        forever #25 MCLK = ~MCLK;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        {ADDR, WDATA, WR} <= {a, d, 1'b1};
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge MCLK);
        {ADDR, RD} <= {a, 1'b1};
        @(posedge MCLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd
    // Order is grant, program, data, byte, io
    task automatic req(input logic [4:0] r, input logic [13:0] a);
        @(posedge MCLK);
        {BUS_GRANTED, CORE_PROG_REQ, CORE_DATA_REQ, CORE_BYTE_REQ, CORE_IO_REQ} <= r;
        CORE_ADDR <= a;
        #1;
    endtask : req
    task automatic pulse(input int n, input logic host);
        repeat (n) begin
            @(posedge MCLK);
            {HOST_PM0_WRITTEN, BYTE_DMA_WORD_DONE} <= {host, !host};
            @(posedge MCLK);
            {HOST_PM0_WRITTEN, BYTE_DMA_WORD_DONE} <= 2'h0;
        end
        tick(2);
    endtask : pulse
    task automatic chip_reset(input logic [2:0] s);
        @(posedge MCLK);
        {straps, RESET_PIN_N} <= {s, 1'b0};
        tick(8);
        @(posedge MCLK);
        RESET_PIN_N <= 1'b1;
        tick(8);
    endtask : chip_reset
    task automatic t_boot(input logic [2:0] s);
        chip_reset(s);
        check("boot", {HOST_MODE, BYTE_BOOT_REQ, EXEC_HOLD_N}, {s[2], 2'b10});
        pulse(31, 1'b0);
        check("held", EXEC_HOLD_N, 1'b0);
        pulse(1, 1'b0);
        check("run", {EXEC_HOLD_N, BYTE_BOOT_REQ, HOST_MODE}, {2'b10, s[2]});
        $display("byte boot %b done", s);
    endtask : t_boot
    task automatic t_full();
        logic [31:0] d;
        logic [2:0]  w [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
        chip_reset(3'b010);
        check("start", {START_EXTERNAL, EXEC_HOLD_N, HOST_MODE, BYTE_BOOT_REQ}, 4'hc);
        rd(mmd_pkg::REG_SELECT, d);
        check("sel_en", d, {28'h0, mmd_pkg::SEL_EN_RESET});
        rd(8'h3c, d);
        check("unmapped", d, 32'h0);
        req(5'h12, 14'h0);
        check("byte_cms", {BYTE_SPACE_SELECT_N, COMBINED_SELECT_N}, 2'b01);
        wr(mmd_pkg::REG_WAIT, 32'h0000d513);
        for (int i = 1; i < 3; i++) begin
            wr(mmd_pkg::REG_OVERLAY, i);
            req(5'h18, 14'h2abc);
            check("pm_addr", EXT_ADDR, {i == 2, 13'h0abc});
            req(5'h18, 14'h0100);
            check("pm_low", EXT_ADDR, 14'h0000);
            wr(mmd_pkg::REG_OVERLAY, i << 4);
            req(5'h14, 14'h2abc);
            check("dm_addr", {WAIT_STATES, EXT_ADDR}, {3'h3, i == 2, 13'h0abc});
        end
        wr(mmd_pkg::REG_OVERLAY, 32'h0);
        req(5'h14, 14'h0100);
        check("dm_int", {INTERNAL_ACCESS, WAIT_STATES}, 4'h8);
        for (int r = 0; r < 4; r++) begin
            req(5'h11, 14'(r * 512 + 511));
            check("io_wait", {IO_SPACE_SELECT_N, WAIT_STATES}, {1'b0, w[r]});
        end
        wr(mmd_pkg::REG_SELECT, 32'h4);
        req(5'h18, 14'h0);
        check("cms_off", {PROGRAM_SPACE_SELECT_N, COMBINED_SELECT_N}, 2'b01);
        req(5'h12, 14'h0);
        check("cms_byte", {BYTE_SPACE_SELECT_N, COMBINED_SELECT_N}, 2'b00);
        wr(mmd_pkg::REG_SYSCTL, 32'h8);
        req(5'h12, 14'h0);
        check("byte_off", {BYTE_SPACE_SELECT_N, COMBINED_SELECT_N}, 2'b11);
        req(5'h0f, 14'h0);
        check("no_grant", {COMBINED_SELECT_N, IO_SPACE_SELECT_N, DATA_SPACE_SELECT_N}, 3'h7);
        $display("full memory test done");
    endtask : t_full
    task automatic t_host();
        chip_reset(3'b101);
        check("host", {HOST_MODE, BYTE_BOOT_REQ, EXEC_HOLD_N}, 3'b100);
        pulse(1, 1'b1);
        check("host_run", EXEC_HOLD_N, 1'b1);
        wr(mmd_pkg::REG_OVERLAY, 32'h10);
        req(5'h14, 14'h3fff);
        check("host_addr", EXT_ADDR, 14'h0001);
        req(5'h18, 14'h0);
        check("host_prog", PROGRAM_SPACE_SELECT_N, 1'b1);
        $display("host boot test done");
    endtask : t_host
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (5) @(posedge MCLK);
        ARST_N <= 1'b1;
        tick(3);
        t_boot(3'b000);
        t_boot(3'b100);
        t_full();
        t_host();
        finish_test();
    end
    // The whole run is under a thousand cycles
    initial begin
        repeat (20000) @(posedge MCLK);
        errors++;
        finish_test();
    end
endmodule : mmd_top_tb
